// file: lic_ctrl.sv
// Purpose: control register bank of a dual line transceiver and the per-channel effects
// Assumes: one 10 MHz clock, host port with read data one cycle after the read strobe
// Notes: pins from outside pass a three-stage synchroniser; outputs are all registered
`include "lic_params.svh"

module lic_ctrl #(
    parameter int NCH = 2
) (
    input wire logic i_ref_clk, // system clock
    input wire logic i_rst, // async reset, active high
    input wire logic [7:0] i_addr, // register address
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [7:0] o_rdata, // read data, cycle after strobe
    input wire logic [NCH-1:0] i_tx_positive_in, // tx positive rail pins
    input wire logic [NCH-1:0] i_tx_negative_in, // tx negative rail pins
    input wire logic [NCH-1:0] i_tx_clock_in, // tx clock pins
    input wire logic [NCH-1:0] i_rec_pos, // recovered rx positive data
    input wire logic [NCH-1:0] i_rec_neg, // recovered rx negative data
    input wire logic [NCH-1:0] i_rec_clk, // recovered rx clock
    input wire logic [NCH-1:0] i_los, // loss of signal per channel
    input wire logic i_mclk_high, // master clock pin held high
    output logic [NCH-1:0] o_rx_positive_out, // rx positive output
    output logic [NCH-1:0] o_rx_negative_out, // rx negative output
    output logic [NCH-1:0] o_rx_clock_out, // rx clock output
    output logic [NCH-1:0] o_transmit_all_ones, // send all ones per channel
    output logic [NCH-1:0] o_loopback_on, // loopback active per channel
    output logic [2*NCH-1:0] o_crit_sel, // 2 bits per channel, lic_crit_t
    output logic [NCH-1:0] o_ais_insert, // rx forced to AIS per channel
    output lic_pkg::lic_ja_cfg_t o_ja_cfg // shared attenuator and line config
);
    logic [7:0] loopback_enable_bits;
    logic [7:0] criteria_select_bits;
    logic [7:0] auto_all_ones_bits;
    logic [7:0] global_ctl;
    logic [7:0] pulse_addr;
    logic [2:0] line_len [4];
    logic [3*NCH-1:0] sync_a;
    logic [3*NCH-1:0] sync_b;
    logic [3*NCH-1:0] sync_c;
    logic [3*NCH-1:0] tx_pins;
    logic [3*NCH-1:0] tx_seen;
    logic mclk_a;
    logic mclk_b;
    logic mclk_c;
    logic mclk_seen;
    logic is_e1;
    logic recovery_mode;
    logic driver_mode;
    logic [7:0] next_rdata;
    logic [NCH-1:0] ais_now;
    lic_pkg::lic_ja_place_t ja_place;
    logic ja_corner;
    logic [6:0] ja_depth;
    logic ja_ami;
    logic ja_protect;

    function automatic logic [7:0] lic_masked(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction

    function automatic lic_pkg::lic_ja_place_t lic_place(input logic lo, input logic hi);
        if (!lo)
            return lic_pkg::lic_ja_off;
        return hi ? lic_pkg::lic_ja_rx : lic_pkg::lic_ja_tx;
    endfunction

    function automatic logic lic_hit(input logic strobe, input logic [7:0] a,
                                     input logic [7:0] off);
        return strobe && (a == off);
    endfunction

    function automatic lic_pkg::lic_crit_t lic_crit_of(input logic e1, input logic sel);
        if (!e1)
            return lic_pkg::lic_crit_t1;
        return sel ? lic_pkg::lic_crit_etsi : lic_pkg::lic_crit_g775;
    endfunction

    // loopback enables, one bit per channel
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            loopback_enable_bits <= `LIC_RST_BYTE;
        end else if (lic_hit(i_wr, i_addr, `LIC_OFF_LOOPBACK)) begin
            loopback_enable_bits <= lic_masked(i_wdata, `LIC_LOOP_MASK);
        end
    end

    // criteria selects, one bit per receiver
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            criteria_select_bits <= `LIC_RST_BYTE;
        end else if (lic_hit(i_wr, i_addr, `LIC_OFF_CRITERIA)) begin
            criteria_select_bits <= lic_masked(i_wdata, `LIC_CRIT_MASK);
        end
    end

    // automatic all-ones enables, one bit per transceiver
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            auto_all_ones_bits <= `LIC_RST_BYTE;
        end else if (lic_hit(i_wr, i_addr, `LIC_OFF_ALL_ONES)) begin
            auto_all_ones_bits <= lic_masked(i_wdata, `LIC_AONE_MASK);
        end
    end

    // global control, shared by both transceivers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            global_ctl <= `LIC_RST_BYTE;
        end else if (lic_hit(i_wr, i_addr, `LIC_OFF_GLOBAL)) begin
            global_ctl <= lic_masked(i_wdata, `LIC_GCR_MASK);
        end
    end

    // pulse shape index
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pulse_addr <= `LIC_RST_BYTE;
        end else if (lic_hit(i_wr, i_addr, `LIC_OFF_PULSE_ADDR)) begin
            pulse_addr <= lic_masked(i_wdata, `LIC_PADDR_MASK);
        end
    end

    // indirect line length store, one per channel or receiver
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 4; k++) begin
                line_len[k] <= `LIC_RST_LEN;
            end
        end else if (i_wr && i_addr == `LIC_OFF_PULSE_DATA && pulse_addr[2] == 1'b0) begin
            line_len[pulse_addr[1:0]] <= i_wdata[2:0];
        end
    end

    // read port, unmapped reads as zero
    always_comb begin
        next_rdata = `LIC_RST_BYTE;
        case (i_addr)
            `LIC_OFF_LOOPBACK: next_rdata = loopback_enable_bits;
            `LIC_OFF_CRITERIA: next_rdata = criteria_select_bits;
            `LIC_OFF_ALL_ONES: next_rdata = auto_all_ones_bits;
            `LIC_OFF_GLOBAL: next_rdata = global_ctl;
            `LIC_OFF_PULSE_ADDR: next_rdata = pulse_addr;
            `LIC_OFF_PULSE_DATA: begin
                if (pulse_addr[2] == 1'b0)
                    next_rdata = {5'h00, line_len[pulse_addr[1:0]]};
            end
            default: next_rdata = `LIC_RST_BYTE;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst)
            o_rdata <= `LIC_RST_BYTE;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= `LIC_RST_BYTE;
    end

    // pin synchronisers, change taken when stages two and three agree
    assign tx_pins = {i_tx_clock_in, i_tx_negative_in, i_tx_positive_in};

    // tx pin stages
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= tx_pins;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // tx pin level taken once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_seen <= '0;
        end else begin
            for (int k = 0; k < 3 * NCH; k++) begin
                if (sync_b[k] == sync_c[k])
                    tx_seen[k] <= sync_c[k];
            end
        end
    end

    // master clock pin stages
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mclk_a <= 1'b0;
            mclk_b <= 1'b0;
            mclk_c <= 1'b0;
        end else begin
            mclk_a <= i_mclk_high;
            mclk_b <= mclk_a;
            mclk_c <= mclk_b;
        end
    end

    // master clock level taken once stages two and three agree
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mclk_seen <= 1'b0;
        end else if (mclk_b == mclk_c) begin
            mclk_seen <= mclk_c;
        end
    end

    // mode decode
    assign is_e1 = (line_len[0] == `LIC_LEN_E1);
    assign recovery_mode = mclk_seen;
    assign driver_mode = mclk_seen & (&tx_seen[3*NCH-1:2*NCH]);

    // alarm insertion: LOS with the insert bit, never in data recovery
    assign ais_now = {NCH{global_ctl[`LIC_GCR_AIS_INS] & ~recovery_mode}} & i_los;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ais_insert <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_ais_insert[c] <= ais_now[c];
            end
        end
    end

    // loopback state per channel
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_loopback_on <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_loopback_on[c] <= loopback_enable_bits[c];
            end
        end
    end

    // all-ones on LOS works in loopback too; blocked when master clock and all tx clock pins are high
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_transmit_all_ones <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_transmit_all_ones[c] <= auto_all_ones_bits[c] & i_los[c] & ~driver_mode;
            end
        end
    end

    // rx positive rail: looped tx pin or recovered data, AIS on top
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_positive_out <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (loopback_enable_bits[c])
                    o_rx_positive_out[c] <= ais_now[c] | tx_seen[c];
                else
                    o_rx_positive_out[c] <= ais_now[c] | i_rec_pos[c];
            end
        end
    end

    // rx negative rail: looped tx pin or recovered data, AIS on top
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_negative_out <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (loopback_enable_bits[c])
                    o_rx_negative_out[c] <= ais_now[c] | tx_seen[NCH + c];
                else
                    o_rx_negative_out[c] <= ais_now[c] | i_rec_neg[c];
            end
        end
    end

    // rx clock: looped tx clock or recovered clock
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_clock_out <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (loopback_enable_bits[c])
                    o_rx_clock_out[c] <= tx_seen[2*NCH + c];
                else
                    o_rx_clock_out[c] <= i_rec_clk[c];
            end
        end
    end

    // detection criteria per receiver
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_crit_sel <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                o_crit_sel[2*c +: 2] <= lic_crit_of(is_e1, criteria_select_bits[c]);
            end
        end
    end

    // attenuator placement, shared by both transceivers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ja_place <= lic_pkg::lic_ja_off;
        end else begin
            ja_place <= lic_place(global_ctl[`LIC_GCR_PLACE_LO],
                                  global_ctl[`LIC_GCR_PLACE_HI]);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ja_corner <= 1'b0;
        end else begin
            ja_corner <= global_ctl[`LIC_GCR_CORNER];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ja_depth <= 7'h00;
        end else begin
            ja_depth <= global_ctl[`LIC_GCR_DEPTH] ?
                        `LIC_DEPTH_DEEP : `LIC_DEPTH_SHALLOW;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ja_ami <= 1'b0;
        end else begin
            ja_ami <= global_ctl[`LIC_GCR_LINE_CODE];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ja_protect <= 1'b0;
        end else begin
            ja_protect <= ~global_ctl[`LIC_GCR_SHORT_OFF];
        end
    end

    assign o_ja_cfg = {ja_place, ja_corner, ja_depth, ja_ami, ja_protect};
endmodule

// file: lic_ctrl_assertions.sv
// Purpose: port checker of the line control bank
// Assumes: outputs follow a register write after two edges
// Notes: mirrors of criteria, all-ones, alarm and line length kept here
module lic_ctrl_assertions #(
    parameter int NCH = 2
) (
    input wire logic i_ref_clk, // clock
    input wire logic i_rst, // async reset
    input wire logic [7:0] i_addr, // address
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic [NCH-1:0] i_los, // loss of signal
    input wire logic [NCH-1:0] o_transmit_all_ones, // all ones
    input wire logic [NCH-1:0] o_loopback_on, // loopback
    input wire logic [2*NCH-1:0] o_crit_sel, // criteria
    input wire logic [NCH-1:0] o_ais_insert, // alarm insertion
    input wire lic_pkg::lic_ja_cfg_t o_ja_cfg // attenuator config
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] idx;
    logic t1;
    logic [1:0] crit;
    logic [1:0] aone;
    logic ais_en;
    wire logic w_lp = i_wr && i_addr == 8'h0C;
    wire logic w_gc = i_wr && i_addr == 8'h0F;
    wire logic [3:0] exp_crit = {t1 ? 2'h0 : {crit[1], !crit[1]}, t1 ? 2'h0 : {crit[0], !crit[0]}};
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            idx <= 3'h0;
            t1 <= 1'b0;
            crit <= 2'h0;
            aone <= 2'h0;
            ais_en <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == 8'h10) idx <= i_wdata[2:0];
            if (i_addr == 8'h11 && idx == 3'h0) t1 <= i_wdata[2:0] != 3'h0;
            if (i_addr == 8'h0D) crit <= i_wdata[1:0];
            if (i_addr == 8'h0E) aone <= i_wdata[1:0];
            if (w_gc) ais_en <= i_wdata[6];
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    loop_follow_a: assert property (w_lp |-> ##2 o_loopback_on == $past(i_wdata[1:0], 2))
        else $error("loopback output does not follow write");
    place_sel_a: assert property (w_gc |-> ##2 o_ja_cfg.place ==
        ($past(i_wdata[0], 2) ? ($past(i_wdata[1], 2) ? 2'h2 : 2'h1) : 2'h0))
        else $error("attenuator place wrong");
    depth_sel_a: assert property (w_gc |-> ##2 o_ja_cfg.depth_bits ==
        ($past(i_wdata[3], 2) ? 7'h40 : 7'h20)) else $error("attenuator depth wrong");
    code_bits_a: assert property (w_gc |-> ##2 {o_ja_cfg.corner_hi, o_ja_cfg.use_ami} ==
        {$past(i_wdata[2], 2), $past(i_wdata[4], 2)}) else $error("corner or line code wrong");
    protect_on_a: assert property (w_gc |-> ##2 o_ja_cfg.short_protect_on != $past(i_wdata[5], 2))
        else $error("short protection wrong");
    ais_cause_a: assert property ((o_ais_insert & ~($past(i_los) & {NCH{$past(ais_en)}})) == 0)
        else $error("alarm insertion without cause");
    ones_cause_a: assert property ((o_transmit_all_ones & ~($past(i_los) & $past(aone))) == 0)
        else $error("all ones without cause");
    crit_map_a: assert property (!$past(i_wr) && !$past(i_rst) && !$past(i_rst, 2) |->
        o_crit_sel == exp_crit) else $error("criteria select wrong");
    reset_zero_a: assert property ($fell(i_rst) |-> o_loopback_on == 0 && o_ja_cfg == 0)
        else $error("outputs not clear after reset");
endmodule
bind lic_ctrl lic_ctrl_assertions #(.NCH(NCH)) u_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_los(i_los),
    .o_transmit_all_ones(o_transmit_all_ones),
    .o_loopback_on(o_loopback_on),
    .o_crit_sel(o_crit_sel),
    .o_ais_insert(o_ais_insert),
    .o_ja_cfg(o_ja_cfg)
);

// file: lic_host.sv
// Purpose: host model on the register port of the line control bank
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes: released address and data lines show the inverse of the address and data given to the task
module lic_host (
    input wire logic i_clk, // bench clock
    output logic [7:0] o_addr, // register address
    output logic [7:0] o_wdata, // write data
    output logic o_wr, // write strobe
    output logic o_rd, // read strobe
    input wire logic [7:0] i_rdata // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= (a == 8'h0E) ? (d & 8'h03) : d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule

// file: lic_params.svh
// Purpose: offsets, field positions, reset values and widths of the line control bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH

`define LIC_ADDR_W 8
`define LIC_DATA_W 8
`define LIC_OFF_LOOPBACK 8'h0C
`define LIC_OFF_CRITERIA 8'h0D
`define LIC_OFF_ALL_ONES 8'h0E
`define LIC_OFF_GLOBAL 8'h0F
`define LIC_OFF_PULSE_ADDR 8'h10
`define LIC_OFF_PULSE_DATA 8'h11
`define LIC_RST_BYTE 8'h00
`define LIC_RST_LEN 3'h0
`define LIC_LOOP_MASK 8'h0F
`define LIC_CRIT_MASK 8'h0F
`define LIC_AONE_MASK 8'h03
`define LIC_GCR_MASK 8'h7F
`define LIC_PADDR_MASK 8'h07
`define LIC_PDATA_MASK 8'h07
`define LIC_LEN_E1 3'h0
`define LIC_GCR_PLACE_LO 0
`define LIC_GCR_PLACE_HI 1
`define LIC_GCR_CORNER 2
`define LIC_GCR_DEPTH 3
`define LIC_GCR_LINE_CODE 4
`define LIC_GCR_SHORT_OFF 5
`define LIC_GCR_AIS_INS 6
`define LIC_DEPTH_SHALLOW 7'h20
`define LIC_DEPTH_DEEP 7'h40

`endif

// file: lic_pkg.sv
// Purpose: shared types of the line control bank
// Assumes: lic_params.svh included for widths
// Notes: no constants here beyond types
`include "lic_params.svh"
package lic_pkg;
    typedef enum logic [1:0] {
        lic_ja_off,
        lic_ja_tx,
        lic_ja_rx
    } lic_ja_place_t;

    typedef enum logic [1:0] {
        lic_crit_t1,
        lic_crit_g775,
        lic_crit_etsi
    } lic_crit_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic clk;
    } lic_line_t;

    typedef struct packed {
        lic_ja_place_t place;
        logic corner_hi;
        logic [6:0] depth_bits;
        logic use_ami;
        logic short_protect_on;
    } lic_ja_cfg_t;
endpackage

// file: line_interface_control_regs_bench.sv
// Purpose: self-checking bench of the line control bank
// Assumes: host model drives the register port
// Notes: recovered rx inputs held at fixed patterns
module line_interface_control_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, mclk = 1'b0;
    logic [1:0] txp = 2'h0, txn = 2'h0, txc = 2'h0, los = 2'h0;
    logic [1:0] rxp, rxn, rxc, aone, lpon, ais;
    logic [3:0] crit;
    lic_pkg::lic_ja_cfg_t cfg;
    int errors = 0;
    int checked = 0;
    always #50 clk = ~clk;
    lic_host i_lic_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .i_rdata(rdata));
    lic_ctrl i_lic_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_positive_in(txp), .i_tx_negative_in(txn),
        .i_tx_clock_in(txc), .i_rec_pos(2'h2), .i_rec_neg(2'h1), .i_rec_clk(2'h0), .i_los(los),
        .i_mclk_high(mclk), .o_rx_positive_out(rxp), .o_rx_negative_out(rxn),
        .o_rx_clock_out(rxc), .o_transmit_all_ones(aone), .o_loopback_on(lpon),
        .o_crit_sel(crit), .o_ais_insert(ais), .o_ja_cfg(cfg));
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_lic_host.rd(a, d);
        chk_pin({8'h00, d}, {8'h00, exp});
    endtask
    task automatic report_and_stop;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_regs;
        logic [7:0] a [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h0B};
        logic [7:0] m [5] = '{8'h0F, 8'h0F, 8'h03, 8'h7F, 8'h00};
        foreach (a[i]) chk_reg(a[i], 8'h00);
        foreach (a[i]) begin
            i_lic_host.wr(a[i], 8'hFF);
            chk_reg(a[i], m[i]);
        end
        $display("t_regs done");
    endtask
    task automatic t_gcr;
        logic [7:0] v [4] = '{8'h01, 8'h03, 8'h02, 8'h3C};
        foreach (v[i]) begin
            i_lic_host.wr(8'h0F, v[i]);
            repeat (2) @(posedge clk);
            chk_pin(16'(cfg), {4'h0, v[i][0] ? (v[i][1] ? 2'h2 : 2'h1) : 2'h0, v[i][2],
                v[i][3] ? 7'h40 : 7'h20, v[i][4], !v[i][5]});
        end
        $display("t_gcr done");
    endtask
    task automatic t_loop;
        logic [1:0] m [2] = '{2'h1, 2'h3};
        txp <= 2'h1;
        txn <= 2'h2;
        txc <= 2'h3;
        foreach (m[i]) begin
            i_lic_host.wr(8'h0C, {6'h00, m[i]});
            repeat (8) @(posedge clk);
            chk_pin({8'h00, lpon, rxp, rxn, rxc}, {8'h00, m[i], 2'h1 & m[i] | 2'h2 & ~m[i],
                2'h2 & m[i] | 2'h1 & ~m[i], 2'h3 & m[i]});
        end
        i_lic_host.wr(8'h0C, 8'h01);
        $display("t_loop done");
    endtask
    task automatic t_los;
        txc <= 2'h0;
        i_lic_host.wr(8'h0D, 8'h00);
        i_lic_host.wr(8'h0E, 8'h01);
        i_lic_host.wr(8'h0F, 8'h40);
        los <= 2'h3;
        repeat (8) @(posedge clk);
        chk_pin({8'h00, aone, ais, rxp, rxn}, 16'h007F);
        mclk <= 1'b1;
        repeat (8) @(posedge clk);
        chk_pin({8'h00, aone, ais, rxp, rxn}, 16'h004C);
        txc <= 2'h3;
        repeat (8) @(posedge clk);
        chk_pin({14'h0000, aone}, 16'h0000);
        los <= 2'h0;
        mclk <= 1'b0;
        $display("t_los done");
    endtask
    task automatic t_crit;
        i_lic_host.wr(8'h0D, 8'h06);
        repeat (2) @(posedge clk);
        chk_pin({12'h000, crit}, 16'h0009);
        i_lic_host.wr(8'h10, 8'h00);
        i_lic_host.wr(8'h11, 8'h03);
        repeat (2) @(posedge clk);
        chk_pin({12'h000, crit}, 16'h0000);
        $display("t_crit done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_gcr;
        t_loop;
        t_los;
        t_crit;
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        report_and_stop;
    end
endmodule
